// ### verilog/sdrsc_pkg.sv
// Constants for the servo drive run and stop sequencing block
package sdrsc_pkg;
    localparam logic [7:0]  OFS_TYPE     = 8'h00;
    localparam logic [7:0]  OFS_SPD1     = 8'h04;
    localparam logic [7:0]  OFS_SPD2     = 8'h08;
    localparam logic [7:0]  OFS_SPD3     = 8'h0c;
    localparam logic [7:0]  OFS_ACC      = 8'h10;
    localparam logic [7:0]  OFS_DEC      = 8'h14;
    localparam logic [7:0]  OFS_TUNE     = 8'h18;
    localparam logic [7:0]  OFS_STATUS   = 8'h1c;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0]  OFS_ALM_CLR  = 8'h28;
    localparam logic [7:0]  OFS_ACT_TYPE = 8'h2c;
    localparam logic [15:0] RST_TYPE     = 16'h0100;
    localparam logic [15:0] RST_SPD1     = 16'h03e8;
    localparam logic [15:0] RST_SPD2     = 16'h05dc;
    localparam logic [15:0] RST_SPD3     = 16'h07d0;
    localparam logic [15:0] RST_ACC      = 16'h03e8;
    localparam logic [15:0] RST_DEC      = 16'h01f4;
    localparam logic [3:0]  RST_TUNE     = 4'h1;
    localparam logic [3:0]  DIGIT_SPEED  = 4'h2;
    localparam logic [3:0]  DIGIT_TORQUE = 4'h4;
    localparam logic [7:0]  ALARM_NONE   = 8'h00;
    localparam logic [7:0]  ALARM_EMG    = 8'he6;
    localparam logic [7:0]  ALARM_FAULT  = 8'h10;
    localparam logic [31:0] RATED_RPM    = 32'h00000bb8;
    localparam int          IRQ_ALARM    = 0;
    localparam int          IRQ_SON      = 1;
    localparam int          IRQ_SOFF     = 2;
    localparam int          IRQ_LIMIT    = 3;
    localparam int          CLK_NS       = 100;
    localparam int          MS_NS        = 1000000;
    localparam int          CYCLES_PER_MS = MS_NS / CLK_NS;
    typedef enum logic [1:0] {ST_OFF, ST_ON, ST_ALARM} sdrsc_state_e;
endpackage

// ### verilog/sdrsc_top.sv
// Run and stop sequencing of a servo drive with an APB register slave
`timescale 1ns/1ps
module sdrsc_top #(
    parameter int unsigned CYCLES_PER_MS = sdrsc_pkg::CYCLES_PER_MS
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        power_good,
    input  wire logic        servo_enable_input,
    input  wire logic        emergency_halt_input,
    input  wire logic        forward_travel_limit,
    input  wire logic        reverse_travel_limit,
    input  wire logic        speed_select_a,
    input  wire logic        speed_select_b,
    input  wire logic        direction_input_c,
    input  wire logic        direction_input_d,
    input  wire logic        fault_input,
    input  wire logic        cmd_pulse,
    input  wire logic        cmd_dir,
    output logic             base_enable,
    output logic             dynamic_brake,
    output logic             servo_locked,
    output logic             motor_step,
    output logic             motor_dir,
    output logic signed [16:0] speed_cmd,
    output logic             torque_ccw,
    output logic             torque_cw,
    output logic             autotune_active,
    output logic      [3:0]  gain_level,
    output logic      [7:0]  alarm_code,
    output logic             irq
);
    sdrsc_pkg::sdrsc_state_e state_reg, state_next;
    logic [15:0] type_reg, spd1_reg, spd2_reg, spd3_reg, acc_reg, dec_reg;
    logic [15:0] type_next, spd1_next, spd2_next, spd3_next, acc_next, dec_next;
    logic [15:0] act_type_reg, act_spd1_reg, act_spd2_reg, act_spd3_reg, act_acc_reg, act_dec_reg;
    logic [15:0] act_type_next, act_spd1_next, act_spd2_next, act_spd3_next, act_acc_next, act_dec_next;
    logic [3:0]  tune_reg, tune_next, act_tune_reg, act_tune_next;
    logic [3:0]  irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next, ev;
    logic        pg_reg, alarm_reg, alarm_next;
    logic [7:0]  code_reg, code_next;
    logic [1:0]  lim_reg;
    logic signed [16:0] ref_reg, ref_next, target;
    logic [31:0] ramp_reg, ramp_next, ramp_lim;
    logic        step_reg, step_next, dir_reg, dir_next, tq_ccw_reg, tq_ccw_next, tq_cw_reg, tq_cw_next;
    logic        wr, rd, mapped, power_up, servo_ok, alarm_raise, alarm_hold, alarm_clr;
    logic        is_speed, is_torque, is_pos, fwd_cmd, rev_cmd, fwd_block, rev_block, running;
    logic [15:0] sel_speed;

    // Bus decode; the slave always answers in the access cycle
    assign wr      = psel && penable && pwrite;
    assign rd      = psel && !pwrite;
    assign pready  = 1'b1;
    always_comb begin
        mapped = 1'b1;
        prdata = 32'h00000000;
        case (paddr)
            sdrsc_pkg::OFS_TYPE:     prdata = {16'h0000, type_reg};
            sdrsc_pkg::OFS_SPD1:     prdata = {16'h0000, spd1_reg};
            sdrsc_pkg::OFS_SPD2:     prdata = {16'h0000, spd2_reg};
            sdrsc_pkg::OFS_SPD3:     prdata = {16'h0000, spd3_reg};
            sdrsc_pkg::OFS_ACC:      prdata = {16'h0000, acc_reg};
            sdrsc_pkg::OFS_DEC:      prdata = {16'h0000, dec_reg};
            sdrsc_pkg::OFS_TUNE:     prdata = {28'h0000000, tune_reg};
            sdrsc_pkg::OFS_STATUS:   prdata = {4'h0, ref_reg, alarm_code, alarm_reg, state_reg};
            sdrsc_pkg::OFS_IRQ_STAT: prdata = {28'h0000000, irq_stat_reg};
            sdrsc_pkg::OFS_IRQ_MASK: prdata = {28'h0000000, irq_mask_reg};
            sdrsc_pkg::OFS_ALM_CLR:  prdata = 32'h00000000;
            sdrsc_pkg::OFS_ACT_TYPE: prdata = {16'h0000, act_type_reg};
            default:                 mapped = 1'b0;
        endcase
        if (!rd) begin
            prdata = 32'h00000000;
        end
    end
    assign pslverr = psel && penable && !mapped;

    // Staged parameters written by software, copied to the active set at power on
    assign power_up = power_good && !pg_reg;
    always_comb begin
        type_next = type_reg;
        spd1_next = spd1_reg;
        spd2_next = spd2_reg;
        spd3_next = spd3_reg;
        acc_next  = acc_reg;
        dec_next  = dec_reg;
        tune_next = tune_reg;
        if (wr) begin
            case (paddr)
                sdrsc_pkg::OFS_TYPE: type_next = pwdata[15:0];
                sdrsc_pkg::OFS_SPD1: spd1_next = pwdata[15:0];
                sdrsc_pkg::OFS_SPD2: spd2_next = pwdata[15:0];
                sdrsc_pkg::OFS_SPD3: spd3_next = pwdata[15:0];
                sdrsc_pkg::OFS_ACC:  acc_next  = pwdata[15:0];
                sdrsc_pkg::OFS_DEC:  dec_next  = pwdata[15:0];
                sdrsc_pkg::OFS_TUNE: tune_next = pwdata[3:0];
                default: ;
            endcase
        end
        act_type_next = act_type_reg;
        act_spd1_next = act_spd1_reg;
        act_spd2_next = act_spd2_reg;
        act_spd3_next = act_spd3_reg;
        act_acc_next  = act_acc_reg;
        act_dec_next  = act_dec_reg;
        act_tune_next = act_tune_reg;
        if (power_up) begin
            act_type_next = type_reg;
            act_spd1_next = spd1_reg;
            act_spd2_next = spd2_reg;
            act_spd3_next = spd3_reg;
            act_acc_next  = acc_reg;
            act_dec_next  = dec_reg;
            act_tune_next = tune_reg;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            type_reg     <= sdrsc_pkg::RST_TYPE;
            spd1_reg     <= sdrsc_pkg::RST_SPD1;
            spd2_reg     <= sdrsc_pkg::RST_SPD2;
            spd3_reg     <= sdrsc_pkg::RST_SPD3;
            acc_reg      <= sdrsc_pkg::RST_ACC;
            dec_reg      <= sdrsc_pkg::RST_DEC;
            tune_reg     <= sdrsc_pkg::RST_TUNE;
            act_type_reg <= sdrsc_pkg::RST_TYPE;
            act_spd1_reg <= sdrsc_pkg::RST_SPD1;
            act_spd2_reg <= sdrsc_pkg::RST_SPD2;
            act_spd3_reg <= sdrsc_pkg::RST_SPD3;
            act_acc_reg  <= sdrsc_pkg::RST_ACC;
            act_dec_reg  <= sdrsc_pkg::RST_DEC;
            act_tune_reg <= sdrsc_pkg::RST_TUNE;
            pg_reg       <= 1'b0;
        end else if (ce) begin
            type_reg     <= type_next;
            spd1_reg     <= spd1_next;
            spd2_reg     <= spd2_next;
            spd3_reg     <= spd3_next;
            acc_reg      <= acc_next;
            dec_reg      <= dec_next;
            tune_reg     <= tune_next;
            act_type_reg <= act_type_next;
            act_spd1_reg <= act_spd1_next;
            act_spd2_reg <= act_spd2_next;
            act_spd3_reg <= act_spd3_next;
            act_acc_reg  <= act_acc_next;
            act_dec_reg  <= act_dec_next;
            act_tune_reg <= act_tune_next;
            pg_reg       <= power_good;
        end
    end

    // Mode decode and direction inputs
    assign is_speed  = act_type_reg[3:0] == sdrsc_pkg::DIGIT_SPEED;
    assign is_torque = act_type_reg[3:0] == sdrsc_pkg::DIGIT_TORQUE;
    assign is_pos    = !is_speed && !is_torque;
    assign fwd_cmd   = is_torque ? direction_input_d : direction_input_c;
    assign rev_cmd   = is_torque ? direction_input_c : direction_input_d;
    assign fwd_block = !forward_travel_limit;
    assign rev_block = !reverse_travel_limit;
    always_comb begin
        case ({speed_select_b, speed_select_a})
            2'b01:   sel_speed = act_spd1_reg;
            2'b10:   sel_speed = act_spd2_reg;
            2'b11:   sel_speed = act_spd3_reg;
            default: sel_speed = 16'h0000;
        endcase
    end

    // Alarm latch; a new cause wins over a clear in the same cycle
    assign servo_ok    = power_good && servo_enable_input;
    assign alarm_raise = !emergency_halt_input || fault_input;
    assign alarm_hold  = alarm_reg || alarm_raise;
    assign alarm_clr   = wr && paddr == sdrsc_pkg::OFS_ALM_CLR && pwdata[0];
    always_comb begin
        alarm_next = alarm_reg;
        code_next  = code_reg;
        if (alarm_raise) begin
            alarm_next = 1'b1;
            code_next  = !emergency_halt_input ? sdrsc_pkg::ALARM_EMG : sdrsc_pkg::ALARM_FAULT;
        end else if (alarm_clr) begin
            alarm_next = 1'b0;
            code_next  = sdrsc_pkg::ALARM_NONE;
        end
        state_next = state_reg;
        case (state_reg)
            sdrsc_pkg::ST_OFF:   if (servo_ok) state_next = sdrsc_pkg::ST_ON;
            sdrsc_pkg::ST_ON:    if (!servo_ok) state_next = sdrsc_pkg::ST_OFF;
            sdrsc_pkg::ST_ALARM: if (!alarm_reg) state_next = sdrsc_pkg::ST_OFF;
            default:             state_next = sdrsc_pkg::ST_OFF;
        endcase
        if (alarm_hold) begin
            state_next = sdrsc_pkg::ST_ALARM;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= sdrsc_pkg::ST_OFF;
            alarm_reg <= 1'b0;
            code_reg  <= sdrsc_pkg::ALARM_NONE;
        end else if (ce) begin
            state_reg <= state_next;
            alarm_reg <= alarm_next;
            code_reg  <= code_next;
        end
    end
    assign running       = state_reg == sdrsc_pkg::ST_ON;
    assign base_enable   = running;
    assign servo_locked  = running;
    assign dynamic_brake = state_reg == sdrsc_pkg::ST_ALARM;
    assign alarm_code    = code_reg;
    assign autotune_active = running;
    assign gain_level    = act_tune_reg;

    // Speed reference with ramp; in speed mode a travel limit zeroes it at once
    always_comb begin
        target = 17'sh00000;
        if (fwd_cmd && !rev_cmd && !fwd_block) begin
            target = signed'({1'b0, sel_speed});
        end else if (rev_cmd && !fwd_cmd && !rev_block) begin
            target = -signed'({1'b0, sel_speed});
        end
        if ((target > 0 && ref_reg >= 0) || (target < 0 && ref_reg <= 0)) begin
            ramp_lim = 32'(act_acc_reg * CYCLES_PER_MS);
        end else begin
            ramp_lim = 32'(act_dec_reg * CYCLES_PER_MS);
        end
        ref_next  = ref_reg;
        ramp_next = 32'h00000000;
        if (!running || is_pos) begin
            ref_next = 17'sh00000;
        end else if (is_torque) begin
            ref_next = signed'({1'b0, sel_speed});
        end else if ((ref_reg > 0 && fwd_block) || (ref_reg < 0 && rev_block)) begin
            ref_next = 17'sh00000;
        end else if (ref_reg != target) begin
            if (ramp_lim == 32'h00000000) begin
                ref_next = target;
            end else begin
                ramp_next = ramp_reg + sdrsc_pkg::RATED_RPM;
                if (ramp_next >= ramp_lim) begin
                    ramp_next = ramp_next - ramp_lim;
                    ref_next  = target > ref_reg ? ref_reg + 17'sh00001 : ref_reg - 17'sh00001;
                end
            end
        end
        tq_ccw_next = running && is_torque && fwd_cmd && !rev_cmd && !fwd_block;
        tq_cw_next  = running && is_torque && rev_cmd && !fwd_cmd && !rev_block;
        step_next   = running && is_pos && cmd_pulse && !(cmd_dir ? fwd_block : rev_block);
        dir_next    = cmd_pulse ? cmd_dir : dir_reg;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_reg    <= 17'sh00000;
            ramp_reg   <= 32'h00000000;
            tq_ccw_reg <= 1'b0;
            tq_cw_reg  <= 1'b0;
            step_reg   <= 1'b0;
            dir_reg    <= 1'b0;
        end else if (ce) begin
            ref_reg    <= ref_next;
            ramp_reg   <= ramp_next;
            tq_ccw_reg <= tq_ccw_next;
            tq_cw_reg  <= tq_cw_next;
            step_reg   <= step_next;
            dir_reg    <= dir_next;
        end
    end
    assign speed_cmd  = ref_reg;
    assign torque_ccw = tq_ccw_reg;
    assign torque_cw  = tq_cw_reg;
    assign motor_step = step_reg;
    assign motor_dir  = dir_reg;

    // Sticky events, write one to clear, set wins
    always_comb begin
        ev = 4'h0;
        ev[sdrsc_pkg::IRQ_ALARM] = alarm_raise && !alarm_reg;
        ev[sdrsc_pkg::IRQ_SON]   = !running && state_next == sdrsc_pkg::ST_ON;
        ev[sdrsc_pkg::IRQ_SOFF]  = running && state_next != sdrsc_pkg::ST_ON;
        ev[sdrsc_pkg::IRQ_LIMIT] = (fwd_block && !lim_reg[0]) || (rev_block && !lim_reg[1]);
        irq_stat_next = irq_stat_reg;
        irq_mask_next = irq_mask_reg;
        if (wr && paddr == sdrsc_pkg::OFS_IRQ_STAT) begin
            irq_stat_next = irq_stat_reg & ~pwdata[3:0];
        end
        if (wr && paddr == sdrsc_pkg::OFS_IRQ_MASK) begin
            irq_mask_next = pwdata[3:0];
        end
        irq_stat_next = irq_stat_next | ev;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
            lim_reg      <= 2'b00;
        end else if (ce) begin
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            lim_reg      <= {rev_block, fwd_block};
        end
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    servo_lock_a: assert property ((ce && state_reg == sdrsc_pkg::ST_OFF && servo_ok && !alarm_hold)
        |=> base_enable && servo_locked && !dynamic_brake) else $error("servo enable did not lock");
    coast_off_a: assert property ((ce && !servo_enable_input && !alarm_hold)
        |=> !base_enable && !dynamic_brake) else $error("servo off did not coast");
    alarm_brake_a: assert property ((ce && fault_input)
        |=> dynamic_brake && !base_enable) else $error("alarm did not brake");
    emg_code_a: assert property ((ce && !emergency_halt_input)
        |=> alarm_code == sdrsc_pkg::ALARM_EMG && dynamic_brake) else $error("emergency code missing");
    limit_stop_a: assert property ((ce && running && servo_ok && !alarm_hold && is_speed && ref_reg > 0 && fwd_block)
        |=> ref_reg == 17'sh00000 && base_enable) else $error("limit stop failed");
    limit_away_a: assert property ((ce && running && servo_ok && !alarm_hold && is_pos && cmd_pulse
        && !cmd_dir && fwd_block && !rev_block) |=> motor_step && !motor_dir) else $error("reverse step blocked");
    conflict_decel_a: assert property ((ce && running && servo_ok && !alarm_hold && is_speed
        && fwd_cmd == rev_cmd && ref_reg > 0) |=> ref_reg <= $past(ref_reg)) else $error("conflict did not decelerate");
    torque_ccw_a: assert property ((ce && running && servo_ok && !alarm_hold && is_torque
        && direction_input_d && !direction_input_c && !fwd_block) |=> torque_ccw && !torque_cw) else $error("no ccw torque");
    param_hold_a: assert property (!(ce && power_up)
        |=> $stable(act_type_reg) && $stable(act_acc_reg)) else $error("parameter applied early");
    servo_on_c: cover property (ce && running ##1 dynamic_brake);
    limit_hit_c: cover property (ce && running && fwd_block && ref_reg > 0);
    torque_run_c: cover property (torque_ccw ##[1:20] torque_cw);
endmodule

// ### bench/sdrsc_host.sv
// Host controller model driving power, servo enable and command pulses
`timescale 1ns/1ps
module sdrsc_host (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic power_req,
    input  wire logic servo_req,
    input  wire logic pulse_req,
    input  wire logic pulse_dir,
    output logic      power_good,
    output logic      servo_enable_input,
    output logic      cmd_pulse,
    output logic      cmd_dir
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_good         <= 1'b0;
            servo_enable_input <= 1'b0;
            cmd_pulse          <= 1'b0;
            cmd_dir            <= 1'b0;
        end else begin
            power_good         <= power_req;
            // Servo enable only follows power that is already up
            servo_enable_input <= servo_req & power_good & power_req;
            cmd_pulse          <= pulse_req;
            // Direction is only meaningful with a pulse, so it wanders otherwise
            cmd_dir            <= pulse_req ? pulse_dir : ~cmd_dir;
        end
    end
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the servo drive run and stop block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, power_good, servo_enable_input, cmd_pulse, cmd_dir;
    logic power_req = 1'b0, servo_req = 1'b0, pulse_req = 1'b0, pulse_dir = 1'b0;
    logic emergency_halt_input = 1'b1, forward_travel_limit = 1'b1, reverse_travel_limit = 1'b1;
    logic speed_select_a = 1'b0, speed_select_b = 1'b0, direction_input_c = 1'b0, direction_input_d = 1'b0;
    logic fault_input = 1'b0, base_enable, dynamic_brake, servo_locked, motor_step, motor_dir;
    logic torque_ccw, torque_cw, autotune_active, irq;
    logic signed [16:0] speed_cmd;
    logic [3:0] gain_level;
    logic [7:0] alarm_code;
    int bad_count = 0, checked = 0;

    sdrsc_host host (.clk, .rst_n, .power_req, .servo_req, .pulse_req, .pulse_dir, .power_good,
                     .servo_enable_input, .cmd_pulse, .cmd_dir);
    // At a 1 ms ramp time this scale gives exactly one rpm per cycle
    sdrsc_top #(.CYCLES_PER_MS(3000)) dut (.clk, .rst_n, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .power_good, .servo_enable_input, .emergency_halt_input,
        .forward_travel_limit, .reverse_travel_limit, .speed_select_a, .speed_select_b, .direction_input_c,
        .direction_input_d, .fault_input, .cmd_pulse, .cmd_dir, .base_enable, .dynamic_brake, .servo_locked,
        .motor_step, .motor_dir, .speed_cmd, .torque_ccw, .torque_cw, .autotune_active, .gain_level,
        .alarm_code, .irq);

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            conclude();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic step(input logic dir, input logic [31:0] exp);
        int cnt;
        cnt = 0;
        pulse_req <= 1'b1;
        pulse_dir <= dir;
        @(posedge clk);
        pulse_req <= 1'b0;
        repeat (6) begin
            @(posedge clk);
            if (motor_step === 1'b1) begin
                cnt++;
                chk("motor_dir", {31'h0, motor_dir}, {31'h0, dir});
            end
        end
        chk("step count", cnt, exp);
    endtask

    task automatic pcycle();
        servo_req <= 1'b0;
        power_req <= 1'b0;
        cyc(4);
        power_req <= 1'b1;
        servo_req <= 1'b1;
        cyc(6);
    endtask

    function automatic logic [31:0] spd(input logic [1:0] s);
        case (s)
            2'b01: return 32'(sdrsc_pkg::RST_SPD1);
            2'b10: return 32'(sdrsc_pkg::RST_SPD2);
            2'b11: return 32'(sdrsc_pkg::RST_SPD3);
            default: return 32'h0;
        endcase
    endfunction

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        conclude();
    end

    initial begin
        cyc(16);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, sdrsc_pkg::OFS_SPD1, 32'h0);
        chk("spd1 reset", q, 32'(sdrsc_pkg::RST_SPD1));
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped err", {31'h0, e}, 32'h1);
        power_req <= 1'b1;
        servo_req <= 1'b1;
        cyc(6);
        chk("base on", {31'h0, base_enable}, 32'h1);
        chk("locked", {31'h0, servo_locked}, 32'h1);
        chk("tuning", {31'h0, autotune_active}, 32'h1);
        chk("gain", {28'h0, gain_level}, {28'h0, sdrsc_pkg::RST_TUNE});
        step(1'b1, 32'h1);
        forward_travel_limit <= 1'b0;
        cyc(3);
        step(1'b1, 32'h0);
        chk("limit base", {31'h0, base_enable}, 32'h1);
        step(1'b0, 32'h1);
        forward_travel_limit <= 1'b1;
        $display("test position done");
        apb(1'b1, sdrsc_pkg::OFS_IRQ_MASK, 32'h1);
        emergency_halt_input <= 1'b0;
        cyc(3);
        chk("emg base", {31'h0, base_enable}, 32'h0);
        chk("emg brake", {31'h0, dynamic_brake}, 32'h1);
        chk("emg code", {24'h0, alarm_code}, {24'h0, sdrsc_pkg::ALARM_EMG});
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, sdrsc_pkg::OFS_IRQ_STAT, 32'hf);
        apb(1'b1, sdrsc_pkg::OFS_IRQ_MASK, 32'h0);
        emergency_halt_input <= 1'b1;
        apb(1'b1, sdrsc_pkg::OFS_ALM_CLR, 32'h1);
        fault_input <= 1'b1;
        cyc(3);
        chk("fault brake", {31'h0, dynamic_brake & ~base_enable}, 32'h1);
        chk("fault code", {24'h0, alarm_code}, {24'h0, sdrsc_pkg::ALARM_FAULT});
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b0, sdrsc_pkg::OFS_IRQ_STAT, 32'h0);
        chk("irq stat", q & 32'h1, 32'h1);
        fault_input <= 1'b0;
        apb(1'b1, sdrsc_pkg::OFS_ALM_CLR, 32'h1);
        cyc(4);
        chk("recover", {31'h0, base_enable}, 32'h1);
        servo_req <= 1'b0;
        cyc(3);
        chk("coast", {30'h0, base_enable, dynamic_brake}, 32'h0);
        $display("test stop done");
        apb(1'b1, sdrsc_pkg::OFS_TYPE, 32'h0102);
        apb(1'b1, sdrsc_pkg::OFS_ACC, 32'h1);
        apb(1'b1, sdrsc_pkg::OFS_DEC, 32'h0);
        apb(1'b0, sdrsc_pkg::OFS_ACT_TYPE, 32'h0);
        chk("type held", q, 32'(sdrsc_pkg::RST_TYPE));
        pcycle();
        apb(1'b0, sdrsc_pkg::OFS_ACT_TYPE, 32'h0);
        chk("type speed", q, 32'h0102);
        speed_select_a <= 1'b1;
        direction_input_c <= 1'b1;
        cyc(11);
        chk("ramp", 32'(speed_cmd), 32'h0000000a);
        apb(1'b1, sdrsc_pkg::OFS_ACC, 32'h0);
        pcycle();
        for (int i = 0; i < 8; i++) begin
            speed_select_a <= i[0];
            speed_select_b <= i[1];
            direction_input_c <= ~i[2];
            direction_input_d <= i[2];
            cyc(30);
            chk("speed", 32'(speed_cmd), i[2] ? -spd(i[1:0]) : spd(i[1:0]));
        end
        for (int j = 0; j < 2; j++) begin
            direction_input_c <= 1'b1;
            direction_input_d <= 1'b0;
            cyc(30);
            direction_input_c <= j[0];
            direction_input_d <= j[0];
            cyc(3);
            chk("both starts", 32'(speed_cmd), 32'h0);
        end
        $display("test speed done");
        apb(1'b1, sdrsc_pkg::OFS_TYPE, 32'h0104);
        pcycle();
        speed_select_a <= 1'b0;
        speed_select_b <= 1'b1;
        direction_input_c <= 1'b0;
        direction_input_d <= 1'b1;
        cyc(3);
        chk("torque fwd", {30'h0, torque_ccw, torque_cw}, 32'h2);
        chk("torque spd", 32'(speed_cmd), spd(2'b10));
        direction_input_c <= 1'b1;
        direction_input_d <= 1'b0;
        cyc(3);
        chk("torque rev", {30'h0, torque_ccw, torque_cw}, 32'h1);
        $display("test torque done");
        conclude();
    end
endmodule
